// *** hw/low_supply_reset_monitor.sv ***
// Low-supply monitor: status flag, configuration and reset sequencing
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module low_supply_reset_monitor #(
    parameter int ADDR_W = supply_mon_pkg::ADDR_W,
    parameter int DATA_W = supply_mon_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Comparator outputs, asynchronous
    input  wire logic              main_below_fall,
    input  wire logic              main_above_rise,
    input  wire logic              reg_below_fall,
    input  wire logic              reg_above_rise,
    // Power mode
    input  wire logic              stop_mode,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_strobe,
    input  wire logic              rd_strobe,
    output logic      [DATA_W-1:0] rdata,
    // Status and reset outputs
    output logic                   supply_low_flag,
    output logic                   chip_reset_req,
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe
);

    localparam int CH = supply_mon_pkg::CHANNELS;

    // Synchronised comparator levels
    logic [3:0]    cmp_raw;
    logic [3:0]    cmp_sync;
    logic [CH-1:0] below_fall_s;
    logic [CH-1:0] above_rise_s;

    // Configuration register and its fields
    logic [7:0]    option_config_one_reg;
    logic [7:0]    option_config_one_next;
    logic          stop_mode_monitor_enable;
    logic          low_supply_reset_disable;
    logic          main_supply_monitor_disable;
    logic          regulator_monitor_disable;

    // Monitor decisions
    logic [CH-1:0] chan_enable;
    logic [CH-1:0] chan_low;
    logic          monitor_active;
    logic          any_low;
    logic          all_high;
    logic          trip;
    logic          flag;

    // Sequencer
    supply_mon_pkg::seq_state_type state_reg;
    supply_mon_pkg::seq_state_type state_next;
    logic          in_hold;
    logic          release_ok;
    logic          pin_oe_reg;
    logic          pin_oe_next;

    // Register port decode
    logic          sel_status;
    logic          sel_config;
    logic          wr_config;
    logic [7:0]    status_word;
    logic [7:0]    config_word;
    logic [7:0]    read_mux;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // Comparators are analog and free-running; never use them raw
    assign cmp_raw = {reg_above_rise, reg_below_fall, main_above_rise, main_below_fall};

    sync_two_stage #(
        .WIDTH    (4)
    ) u_cmp_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (cmp_raw),
        .sync_out (cmp_sync)
    );

    assign below_fall_s[supply_mon_pkg::CH_MAIN] = cmp_sync[0];
    assign above_rise_s[supply_mon_pkg::CH_MAIN] = cmp_sync[1];
    assign below_fall_s[supply_mon_pkg::CH_REG]  = cmp_sync[2];
    assign above_rise_s[supply_mon_pkg::CH_REG]  = cmp_sync[3];

    // Configuration fields
    assign stop_mode_monitor_enable    = option_config_one_reg[supply_mon_pkg::STOP_EN_BIT];
    assign low_supply_reset_disable    = option_config_one_reg[supply_mon_pkg::RST_DIS_BIT];
    assign main_supply_monitor_disable = option_config_one_reg[supply_mon_pkg::MAIN_DIS_BIT];
    assign regulator_monitor_disable   = option_config_one_reg[supply_mon_pkg::REG_DIS_BIT];

    // Per-channel enables
    assign chan_enable[supply_mon_pkg::CH_MAIN] = !main_supply_monitor_disable;
    assign chan_enable[supply_mon_pkg::CH_REG]  = !regulator_monitor_disable;

    generate
        for (genvar i = 0; i < CH; i++) begin : g_chan
            assign chan_low[i] = below_fall_s[i] && chan_enable[i];
        end
    endgenerate

    // Wait mode is deliberately not an input: the monitor ignores it
    assign monitor_active = !stop_mode || stop_mode_monitor_enable;

    assign any_low  = |chan_low;
    assign all_high = &above_rise_s;

    // A reset starts only when active and not disabled
    assign trip = any_low && monitor_active && !low_supply_reset_disable;

    // Status flag with hysteresis
    hyst_latch #(
        .RESET_VALUE (supply_mon_pkg::FLAG_RESET)
    ) u_flag (
        .clk         (clk),
        .resetn      (resetn),
        .enable      (monitor_active),
        .set         (any_low),
        .clear       (all_high),
        .q           (flag)
    );

    // Release needs both rails back, whatever the disable bits say
    assign release_ok = all_high;

    assign in_hold = (state_reg == supply_mon_pkg::ST_HOLD);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            supply_mon_pkg::ST_MONITOR: begin
                if (trip) begin
                    state_next = supply_mon_pkg::ST_HOLD;
                end
            end
            supply_mon_pkg::ST_HOLD: begin
                if (release_ok) begin
                    state_next = supply_mon_pkg::ST_MONITOR;
                end
            end
            default: begin
                state_next = supply_mon_pkg::ST_HOLD;
            end
        endcase
    end

    // Pin enable registered beside the state, so the pin never glitches
    assign pin_oe_next = (state_next == supply_mon_pkg::ST_HOLD);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg  <= supply_mon_pkg::ST_MONITOR;
            pin_oe_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Reset outputs; the pin is open drain and only ever pulled low
    assign chip_reset_req = in_hold;
    assign reset_pin_oe   = pin_oe_reg;
    assign reset_pin_out  = supply_mon_pkg::PIN_LOW;

    // Register decode
    assign sel_status = (addr == supply_mon_pkg::STATUS_OFFSET);
    assign sel_config = (addr == supply_mon_pkg::CONFIG_OFFSET);
    assign wr_config  = wr_strobe && sel_config;

    // Disable bits reset to zero, so the monitor is live at once
    assign option_config_one_next = wr_config ? (wdata[7:0] & supply_mon_pkg::CONFIG_MASK)
                                              : option_config_one_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            option_config_one_reg <= supply_mon_pkg::CONFIG_RESET;
        end else begin
            option_config_one_reg <= option_config_one_next;
        end
    end

    // Status is read-only; writes to it are dropped
    assign status_word = {flag, 7'h00};
    assign config_word = option_config_one_reg;

    assign read_mux = sel_status ? status_word :
                      sel_config ? config_word : 8'h00;

    // Read data stand only in the cycle after the strobe
    assign rdata_next = rd_strobe ? read_mux[DATA_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata           = rdata_reg;
    assign supply_low_flag = flag;

    // Checks

    AST_ARMED_AFTER_RESET: assert property (@(posedge clk)
        $rose(resetn) |-> !main_supply_monitor_disable && !regulator_monitor_disable
                          && !low_supply_reset_disable)
        else $error("monitor not armed after reset");

    AST_PIN_WITH_RESET: assert property (@(posedge clk) disable iff (!resetn)
        $rose(chip_reset_req) |-> reset_pin_oe && !reset_pin_out)
        else $error("reset pin not driven low with chip reset");

    AST_HOLD_UNTIL_RISE: assert property (@(posedge clk) disable iff (!resetn)
        in_hold && !(above_rise_s[0] && above_rise_s[1]) |=> in_hold)
        else $error("reset released before both supplies recovered");

    AST_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
        in_hold && above_rise_s[0] && above_rise_s[1] |=> !chip_reset_req ##1 !reset_pin_oe)
        else $error("reset not released after recovery");

    AST_MAIN_DISABLED: assert property (@(posedge clk) disable iff (!resetn)
        !in_hold && main_supply_monitor_disable && !chan_low[1] |=> !in_hold)
        else $error("disabled main comparator caused reset");

    AST_REG_DISABLED: assert property (@(posedge clk) disable iff (!resetn)
        !in_hold && regulator_monitor_disable && !chan_low[0] |=> !in_hold)
        else $error("disabled regulator comparator caused reset");

    AST_POLLED_NO_RESET: assert property (@(posedge clk) disable iff (!resetn)
        !in_hold && low_supply_reset_disable |=> !chip_reset_req)
        else $error("reset issued while resets disabled");

    AST_FORCED_RESET: assert property (@(posedge clk) disable iff (!resetn)
        !in_hold && below_fall_s[0] && !main_supply_monitor_disable
        && !low_supply_reset_disable && monitor_active |=> chip_reset_req ##1 reset_pin_oe)
        else $error("main supply drop did not reset");

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
        monitor_active && any_low |=> flag)
        else $error("flag not set on low supply");

    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        monitor_active && !any_low && all_high |=> !flag)
        else $error("flag not cleared on recovery");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        monitor_active && !any_low && !all_high |=> $stable(flag))
        else $error("flag changed inside hysteresis band");

    AST_STATUS_READ: assert property (@(posedge clk) disable iff (!resetn)
        rd_strobe && sel_status |=> rdata == {$past(flag), 7'h00})
        else $error("status read wrong");

    AST_FLAG_RESET: assert property (@(posedge clk)
        !resetn |=> !supply_low_flag)
        else $error("reset did not clear flag");

    AST_STOP_INACTIVE: assert property (@(posedge clk) disable iff (!resetn)
        stop_mode && !stop_mode_monitor_enable && !in_hold |=> $stable(flag) && !in_hold)
        else $error("monitor acted in stop mode while not enabled");

    AST_STOP_RESET: assert property (@(posedge clk) disable iff (!resetn)
        stop_mode && stop_mode_monitor_enable && !low_supply_reset_disable
        && any_low && !in_hold |=> chip_reset_req)
        else $error("low supply in stop mode did not reset");

    AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (!resetn)
        $rose(main_below_fall) ##1 main_below_fall |=> below_fall_s[0])
        else $error("comparator synchroniser latency wrong");

    AST_SYNC_REG_FALL: assert property (@(posedge clk) disable iff (!resetn)
        $rose(reg_below_fall) ##1 reg_below_fall |=> below_fall_s[1])
        else $error("regulator fall synchroniser latency wrong");

    AST_SYNC_REG_RISE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(reg_above_rise) ##1 reg_above_rise |=> above_rise_s[1])
        else $error("regulator rise synchroniser latency wrong");

    AST_OE_WITH_REQ: assert property (@(posedge clk) disable iff (!resetn)
        reset_pin_oe == chip_reset_req)
        else $error("reset pin enable out of step with chip reset");

    AST_REQ_CAUSE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(chip_reset_req) |-> $past(trip))
        else $error("chip reset raised without a trip");

    AST_NO_SPURIOUS_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !in_hold && !any_low |=> !in_hold)
        else $error("reset entered with no enabled low supply");

    // Configuration fields take the written value one cycle after the strobe
    AST_CFG_MAIN_DIS: assert property (@(posedge clk) disable iff (!resetn)
        wr_config |=> main_supply_monitor_disable == $past(wdata[supply_mon_pkg::MAIN_DIS_BIT]))
        else $error("main disable bit not written");

    AST_CFG_REG_DIS: assert property (@(posedge clk) disable iff (!resetn)
        wr_config |=> regulator_monitor_disable == $past(wdata[supply_mon_pkg::REG_DIS_BIT]))
        else $error("regulator disable bit not written");

    AST_CFG_RST_DIS: assert property (@(posedge clk) disable iff (!resetn)
        wr_config |=> low_supply_reset_disable == $past(wdata[supply_mon_pkg::RST_DIS_BIT]))
        else $error("reset disable bit not written");

    AST_CFG_STOP_EN: assert property (@(posedge clk) disable iff (!resetn)
        wr_config |=> stop_mode_monitor_enable == $past(wdata[supply_mon_pkg::STOP_EN_BIT]))
        else $error("stop enable bit not written");

    AST_WAIT_RESET: assert property (@(posedge clk) disable iff (!resetn)
        !stop_mode && !low_supply_reset_disable && any_low && !in_hold |=> chip_reset_req)
        else $error("low supply outside stop mode did not reset");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!resetn)
        rd_strobe && !sel_status && !sel_config |=> rdata == '0)
        else $error("unmapped read not zero");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        !rd_strobe |=> rdata == '0)
        else $error("read data stood beyond one cycle");

endmodule

// *** hw/supply_mon_pkg.sv ***
// Constants, register map and state codes for the low-supply monitor
package supply_mon_pkg;

    // Register port geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [15:0] STATUS_OFFSET = 16'hFE0F;
    localparam logic [15:0] CONFIG_OFFSET = 16'hFE10;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic       FLAG_RESET   = 1'b0;

    // Status field
    localparam int FLAG_BIT = 7;

    // Configuration fields of option_config_one
    localparam int STOP_EN_BIT  = 0;
    localparam int RST_DIS_BIT  = 1;
    localparam int MAIN_DIS_BIT = 2;
    localparam int REG_DIS_BIT  = 3;
    localparam logic [7:0] CONFIG_MASK = 8'h0F;

    // Comparator channels: index 0 main supply, index 1 regulator
    localparam int CHANNELS  = 2;
    localparam int CH_MAIN   = 0;
    localparam int CH_REG    = 1;

    // Open-drain reset pin level while driven
    localparam logic PIN_LOW = 1'b0;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_MONITOR = 2'b01,
        ST_HOLD    = 2'b10
    } seq_state_type;

endpackage

// *** hw/sync_two_stage.sv ***
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module sync_two_stage #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // Stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule

// *** hw/hyst_latch.sv ***
// Set/clear/hold latch with the set taking priority
`timescale 1ns/1ps
module hyst_latch #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Control
    input  wire logic enable,
    input  wire logic set,
    input  wire logic clear,
    // State
    output logic      q
);

    logic q_reg;
    logic q_next;

    // Set wins over clear so a new low condition is never lost while enabled; with enable low the latch holds
    assign q_next = !enable ? q_reg :
                    set     ? 1'b1  :
                    clear   ? 1'b0  : q_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q_reg <= RESET_VALUE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule

// *** verification/supply_comparator_model.sv ***
// Behavioural model of the two supply comparators facing the monitor
`timescale 1ns/1ps
module supply_comparator_model (
    // Rail levels: 0 below falling, 1 inside hysteresis band, 2 above rising
    input  wire logic [1:0] main_level,
    input  wire logic [1:0] reg_level,
    // Comparator outputs
    output logic            main_below_fall,
    output logic            main_above_rise,
    output logic            reg_below_fall,
    output logic            reg_above_rise
);
    // Inside the band neither output is high, as on a real comparator pair
    assign main_below_fall = (main_level == 2'h0);
    assign main_above_rise = (main_level == 2'h2);
    assign reg_below_fall  = (reg_level == 2'h0);
    assign reg_above_rise  = (reg_level == 2'h2);
endmodule

// *** verification/tb_top.sv ***
// Self-checking testbench for the low-supply monitor
`timescale 1ns/1ps
module tb_top;
    localparam logic [1:0] LO = 2'h0;
    localparam logic [1:0] MID = 2'h1;
    localparam logic [1:0] HI = 2'h2;
    localparam logic [15:0] ST = supply_mon_pkg::STATUS_OFFSET;
    localparam logic [15:0] CF = supply_mon_pkg::CONFIG_OFFSET;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        stop_mode = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic [1:0]  main_lvl = 2'h2;
    logic [1:0]  reg_lvl = 2'h2;
    logic        mbf, mar, rbf, rar;
    logic [7:0]  rdata;
    logic        flag, req, pin_out, pin_oe;
    logic [7:0]  d;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #12.5 clk = ~clk;

    supply_comparator_model i_cmp (
        .main_level      (main_lvl),
        .reg_level       (reg_lvl),
        .main_below_fall (mbf),
        .main_above_rise (mar),
        .reg_below_fall  (rbf),
        .reg_above_rise  (rar)
    );

    low_supply_reset_monitor i_dut (
        .clk             (clk),
        .resetn          (resetn),
        .main_below_fall (mbf),
        .main_above_rise (mar),
        .reg_below_fall  (rbf),
        .reg_above_rise  (rar),
        .stop_mode       (stop_mode),
        .addr            (addr),
        .wdata           (wdata),
        .wr_strobe       (wr_strobe),
        .rd_strobe       (rd_strobe),
        .rdata           (rdata),
        .supply_low_flag (flag),
        .chip_reset_req  (req),
        .reset_pin_out   (pin_out),
        .reset_pin_oe    (pin_oe)
    );

    task automatic stop_test;
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Bounds the whole run; all scenarios need well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string msg);
        tests_run++;
        if (act !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, act, exp);
        end
    endtask

    task automatic outs(input logic f, input logic r, input string msg);
        chk({7'h00, flag}, {7'h00, f}, msg);
        chk({7'h00, req}, {7'h00, r}, msg);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_lvl(input logic [1:0] m, input logic [1:0] r);
        @(posedge clk);
        main_lvl <= m;
        reg_lvl <= r;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        stop_mode <= 1'b0;
        main_lvl <= HI;
        reg_lvl <= HI;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
    endtask

    task automatic t_reset_values;
        do_reset();
        rd(ST, d);
        chk(d, 8'h00, "status reset");
        wait_n(1);
        chk(rdata, 8'h00, "read data one cycle");
        rd(CF, d);
        chk(d, 8'h00, "config reset");
        rd(16'hFE11, d);
        chk(d, 8'h00, "unmapped read");
        outs(1'b0, 1'b0, "idle outputs");
        chk({7'h00, pin_oe}, 8'h00, "pin idle");
    endtask

    // Wait mode has no input, so this also covers behaviour in wait
    task automatic t_forced;
        do_reset();
        set_lvl(LO, HI);
        wait_n(2);
        outs(1'b0, 1'b0, "before sync");
        wait_n(1);
        outs(1'b1, 1'b1, "main drop");
        chk({7'h00, pin_oe}, 8'h01, "pin with reset");
        wait_n(1);
        chk({6'h00, pin_out, pin_oe}, 8'h01, "pin driven low");
        set_lvl(MID, HI);
        wait_n(6);
        outs(1'b1, 1'b1, "band main");
        set_lvl(HI, MID);
        wait_n(6);
        outs(1'b1, 1'b1, "band reg");
        set_lvl(HI, HI);
        wait_n(3);
        outs(1'b0, 1'b0, "recovered");
        wait_n(1);
        chk({7'h00, pin_oe}, 8'h00, "pin released");
    endtask

    task automatic t_polled;
        do_reset();
        wr(CF, 8'hF2);
        rd(CF, d);
        chk(d, 8'h02, "config mask");
        set_lvl(LO, HI);
        wait_n(4);
        outs(1'b1, 1'b0, "polled drop");
        chk({7'h00, pin_oe}, 8'h00, "no pin");
        rd(ST, d);
        chk(d, 8'h80, "status set");
        wr(ST, 8'h00);
        rd(ST, d);
        chk(d, 8'h80, "status read only");
        set_lvl(MID, MID);
        wait_n(4);
        rd(ST, d);
        chk(d, 8'h80, "status holds");
        set_lvl(HI, HI);
        wait_n(4);
        rd(ST, d);
        chk(d, 8'h00, "status clear");
        set_lvl(HI, LO);
        wait_n(4);
        outs(1'b1, 1'b0, "reg drop polled");
    endtask

    task automatic t_disable;
        do_reset();
        wr(CF, 8'h04);
        set_lvl(LO, HI);
        wait_n(4);
        chk({7'h00, req}, 8'h00, "main disabled");
        set_lvl(LO, LO);
        wait_n(4);
        chk({7'h00, req}, 8'h01, "reg still armed");
        set_lvl(HI, HI);
        wait_n(4);
        wr(CF, 8'h08);
        set_lvl(HI, LO);
        wait_n(4);
        chk({7'h00, req}, 8'h00, "reg disabled");
        set_lvl(LO, LO);
        wait_n(4);
        chk({7'h00, req}, 8'h01, "main still armed");
        set_lvl(HI, HI);
        wait_n(4);
    endtask

    task automatic t_stop;
        do_reset();
        @(posedge clk);
        stop_mode <= 1'b1;
        set_lvl(LO, HI);
        wait_n(4);
        outs(1'b0, 1'b0, "stop inactive");
        wr(CF, 8'h01);
        wait_n(4);
        outs(1'b1, 1'b1, "stop active reset");
        set_lvl(HI, HI);
        stop_mode <= 1'b0;
        wait_n(4);
    endtask

    initial begin
        t_reset_values();
        t_forced();
        t_polled();
        t_disable();
        t_stop();
        stop_test();
    end
endmodule
